//--- src/io_port_decode.sv
/*
  Host I/O port logic of a four-channel board: group decode, channel
  ordering, control channel output split and status word assembly.
  Assumes one synchronous clock; host strobes are one cycle long.
*/
`timescale 1ns/1ps
// Functional notes
// - Answer one group of four among 256
// - Group chosen by A7..A2 versus config
// - Default order A, B, C, D
// - Alternate order C, D, A, B
// - Config load follows strobe or held high
// - Data bits 7..4 drive serial conditions
// - Data bits 3..0 into holding latch
// - Control read returns selectable status word
// - Sticky channel A/B available flags
// - External received latches feed status directly
// - Four EIA levels selectable as status
module io_port_decode
  import io_port_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire io_port_pkg::bus_req_s busReq,
  output logic [io_port_pkg::DATA_W-1:0] rdData,
  output logic rdDataOe,
  input wire logic [io_port_pkg::GROUP_W-1:0] groupSelect,
  input wire logic alternateOrder,
  input wire logic softwareMode,
  input wire logic driverFromBit1,
  input wire io_port_pkg::status_sel_t statusSelect,
  input wire logic parity_error,
  input wire logic framing_error,
  input wire logic overrun_error,
  input wire logic receive_word_ready,
  input wire logic transmit_buffer_empty,
  input wire logic ext_avail_strobe_a,
  input wire logic ext_avail_strobe_b,
  input wire logic ext_received_latch_a,
  input wire logic ext_received_latch_b,
  input wire logic [io_port_pkg::EIA_W-1:0] eiaIn,
  input wire logic [io_port_pkg::DATA_W-1:0] chanAIn,
  input wire logic [io_port_pkg::DATA_W-1:0] chanBIn,
  input wire logic [io_port_pkg::DATA_W-1:0] serialRxData,
  output logic [io_port_pkg::NUM_CHAN-1:0] chanRead,
  output logic [io_port_pkg::NUM_CHAN-1:0] chanWrite,
  output logic [io_port_pkg::DATA_W-1:0] outData,
  output logic [io_port_pkg::COND_W-1:0] conditionOut,
  output logic configLoad,
  output logic [io_port_pkg::LATCH_W-1:0] holdLatch,
  output logic driverOut,
  output logic ext_avail_flag_a,
  output logic ext_avail_flag_b
);

  import io_port_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // Channel reached by the two low address bits
  function automatic chan_e map_channel(input logic [LOW_W-1:0] low,
                                        input logic alt);
    logic [LOW_W-1:0] code;
    begin
      code = alt ? (low ^ ALT_SWAP) : low;
      return chan_e'(code);
    end
  endfunction

  // One-hot strobe vector for a channel
  function automatic logic [NUM_CHAN-1:0] chan_hot(input chan_e ch,
                                                   input logic en);
    logic [NUM_CHAN-1:0] hot;
    begin
      hot = '0;
      hot[ch] = en;
      return hot;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [GROUP_W-1:0] upperAddr;
  logic [LOW_W-1:0] lowAddr;
  logic groupHit;
  chan_e channel;
  logic rdHit;
  logic wrHit;
  logic [NUM_CHAN-1:0] rdHot;
  logic [NUM_CHAN-1:0] wrHot;

  assign upperAddr = busReq.addr[ADDR_W-1:LOW_W];
  assign lowAddr = busReq.addr[LOW_W-1:0];
  // Only the configured group of four answers
  assign groupHit = (upperAddr == groupSelect);
  // Address bits A7..A2 against the strapped value, zero means ground
  assign rdHit = busReq.rd & groupHit;
  assign wrHit = busReq.wr & groupHit;
  // Plain order places A first, alternate order places C first
  assign channel = map_channel(lowAddr, alternateOrder);
  assign rdHot = chan_hot(channel, rdHit);
  assign wrHot = chan_hot(channel, wrHit);

  // Read strobes go out in the request cycle so data can be sampled
  assign chanRead = rdHot;

  //////////////////////////////////////////////////////////////////////////
  // Channel A and B available flags

  logic flagA_ff;
  logic flagB_ff;
  logic nxt_flagA;
  logic nxt_flagB;
  logic clearA;
  logic clearB;

  // Reading the channel data acknowledges its flag
  assign clearA = rdHot[CHAN_A];
  assign clearB = rdHot[CHAN_B];
  // A strobe in the clearing cycle wins so no arrival is lost
  assign nxt_flagA = ext_avail_strobe_a | (flagA_ff & ~clearA);
  assign nxt_flagB = ext_avail_strobe_b | (flagB_ff & ~clearB);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flagA_ff <= 1'b0;
      flagB_ff <= 1'b0;
    end
    else
    begin
      flagA_ff <= nxt_flagA;
      flagB_ff <= nxt_flagB;
    end
  end

  assign ext_avail_flag_a = flagA_ff;
  assign ext_avail_flag_b = flagB_ff;

  //////////////////////////////////////////////////////////////////////////
  // Status word

  status_src_s sources;
  logic [STATUS_BITS-1:0] statusWord;

  assign sources.parity_error = parity_error;
  assign sources.framing_error = framing_error;
  assign sources.overrun_error = overrun_error;
  assign sources.receive_word_ready = receive_word_ready;
  assign sources.transmit_buffer_empty = transmit_buffer_empty;
  assign sources.ext_avail_flag_a = flagA_ff;
  assign sources.ext_avail_flag_b = flagB_ff;
  // External latches are passed through without storage
  assign sources.received_latch_in_a = ext_received_latch_a;
  assign sources.received_latch_in_b = ext_received_latch_b;
  assign sources.eia = eiaIn;

  // Each bit has its own selector, like a jumper per terminal
  genvar gi;
  generate
    for (gi = 0; gi < STATUS_BITS; gi++)
    begin : g_status
      status_bit_select u_sel
      (
        .select(statusSelect[gi]),
        .sources(sources),
        .bitOut(statusWord[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Read data path

  logic [DATA_W-1:0] readMux;
  logic [DATA_W-1:0] rdData_ff;
  logic [DATA_W-1:0] nxt_rdData;
  logic rdDataOe_ff;

  assign readMux = (channel == CHAN_A) ? chanAIn :
                   (channel == CHAN_B) ? chanBIn :
                   (channel == CHAN_C) ? statusWord :
                   serialRxData;
  // Outside a hit the bus holds zero and the enable stays low
  assign nxt_rdData = rdHit ? readMux : DATA_RST;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData_ff <= DATA_RST;
      rdDataOe_ff <= 1'b0;
    end
    else
    begin
      rdData_ff <= nxt_rdData;
      rdDataOe_ff <= rdHit;
    end
  end

  assign rdData = rdData_ff;
  assign rdDataOe = rdDataOe_ff;

  //////////////////////////////////////////////////////////////////////////
  // Write data path

  logic [DATA_W-1:0] outData_ff;
  logic [NUM_CHAN-1:0] chanWrite_ff;
  logic [COND_W-1:0] cond_ff;
  logic [LATCH_W-1:0] latch_ff;
  logic ctrlWrite;
  logic [DATA_W-1:0] nxt_outData;
  logic [COND_W-1:0] nxt_cond;
  logic [LATCH_W-1:0] nxt_latch;

  assign ctrlWrite = wrHot[CHAN_C];
  // Last written word stays up for the channel being strobed
  assign nxt_outData = wrHit ? busReq.wrData : outData_ff;
  assign nxt_cond = ctrlWrite ?
                    busReq.wrData[COND_LSB +: COND_W] : cond_ff;
  assign nxt_latch = ctrlWrite ?
                     busReq.wrData[LATCH_LSB +: LATCH_W] : latch_ff;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outData_ff <= DATA_RST;
      chanWrite_ff <= '0;
      cond_ff <= COND_RST;
      latch_ff <= LATCH_RST;
    end
    else
    begin
      outData_ff <= nxt_outData;
      chanWrite_ff <= wrHot;
      cond_ff <= nxt_cond;
      latch_ff <= nxt_latch;
    end
  end

  // Strobes lag one cycle so they line up with the registered data
  assign chanWrite = chanWrite_ff;
  assign outData = outData_ff;
  assign conditionOut = cond_ff;
  assign holdLatch = latch_ff;

  //////////////////////////////////////////////////////////////////////////
  // Serial configuration load and peripheral driver

  // Software mode reloads conditions on every control write, so the
  // upper bits must be rewritten unchanged when only the latch moves
  assign configLoad = softwareMode ? chanWrite_ff[CHAN_C] : 1'b1;

  assign driverOut = driverFromBit1 ? latch_ff[1] : latch_ff[0];

endmodule

//--- src/io_port_pkg.sv
/*
  Shared constants, types and status source codes of the I/O port block.
  Assumes an 8-bit host I/O bus with 256 port addresses.
*/
package io_port_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int GROUP_W = 6;
  localparam int LOW_W = 2;
  localparam int NUM_GROUPS = 64;
  localparam int NUM_CHAN = 4;
  localparam int STATUS_BITS = 8;
  localparam int SEL_W = 4;
  localparam int LATCH_W = 4;
  localparam int COND_W = 4;
  localparam int EIA_W = 4;
  localparam int SRC_VEC_W = 16;

  // Field positions in a channel C output word
  localparam int LATCH_LSB = 0;
  localparam int COND_LSB = 4;

  // Low address bits are flipped in A1 for the alternate order
  localparam logic [LOW_W-1:0] ALT_SWAP = 2'h2;

  localparam logic [LATCH_W-1:0] LATCH_RST = 4'h0;
  localparam logic [COND_W-1:0] COND_RST = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [1:0] {
    CHAN_A = 2'b00,
    CHAN_B = 2'b01,
    CHAN_C = 2'b10,
    CHAN_D = 2'b11
  } chan_e;

  // Source codes for one status word bit; 4'he and 4'hf read zero
  typedef enum logic [SEL_W-1:0] {
    SRC_ZERO = 4'h0,
    SRC_PARITY_ERROR = 4'h1,
    SRC_FRAMING_ERROR = 4'h2,
    SRC_OVERRUN_ERROR = 4'h3,
    SRC_RECEIVE_READY = 4'h4,
    SRC_TRANSMIT_EMPTY = 4'h5,
    SRC_AVAIL_FLAG_A = 4'h6,
    SRC_AVAIL_FLAG_B = 4'h7,
    SRC_LATCH_IN_A = 4'h8,
    SRC_LATCH_IN_B = 4'h9,
    SRC_EIA_0 = 4'ha,
    SRC_EIA_1 = 4'hb,
    SRC_EIA_2 = 4'hc,
    SRC_EIA_3 = 4'hd
  } status_src_e;

  typedef logic [STATUS_BITS-1:0][SEL_W-1:0] status_sel_t;

  typedef struct packed {
    logic parity_error;
    logic framing_error;
    logic overrun_error;
    logic receive_word_ready;
    logic transmit_buffer_empty;
    logic ext_avail_flag_a;
    logic ext_avail_flag_b;
    logic received_latch_in_a;
    logic received_latch_in_b;
    logic [EIA_W-1:0] eia;
  } status_src_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic wr;
    logic rd;
  } bus_req_s;

endpackage

//--- src/status_bit_select.sv
/*
  One status word bit: picks one source out of the flag set by code.
  Assumes the code is static configuration or changes between reads.
*/
`timescale 1ns/1ps
module status_bit_select
  import io_port_pkg::*;
(
  input wire logic [io_port_pkg::SEL_W-1:0] select,
  input wire io_port_pkg::status_src_s sources,
  output logic bitOut
);

  logic [SRC_VEC_W-1:0] srcVec;

  // Bit position equals source code
  assign srcVec = {2'h0, sources.eia,
                   sources.received_latch_in_b, sources.received_latch_in_a,
                   sources.ext_avail_flag_b, sources.ext_avail_flag_a,
                   sources.transmit_buffer_empty, sources.receive_word_ready,
                   sources.overrun_error, sources.framing_error,
                   sources.parity_error, 1'b0};
  assign bitOut = srcVec[select];

endmodule

//--- test/host_model.sv
/*
  Host bus master model for the I/O port block.
  Assumes one-cycle strobes taken at a rising edge, read data one cycle later.
*/
`timescale 1ns/1ps
module host_model
  import io_port_pkg::*;
(
  input wire logic clock,
  output io_port_pkg::bus_req_s busReq,
  input wire logic [7:0] rdData
);
  initial busReq = '0;
  // Ends mid-cycle so one-cycle write results can be checked settled;
  // the caller waits for a rising edge before driving again
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    busReq <= '0;
    @(negedge clock);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    busReq <= '0;
    @(negedge clock);
    d = rdData;
    @(posedge clock);
  endtask
  // Teleprinter setup: every mode bit high
  task automatic tele(input logic [7:0] a, input logic [3:0] lo);
    wr(a, {4'hf, lo});
  endtask
  // No interrupt path, so the status word is polled, bounded
  task automatic poll(input logic [7:0] a, input logic [7:0] m,
                      output logic ok);
    logic [7:0] d;
    ok = 1'b0;
    repeat (20)
      if (!ok)
      begin
        rd(a, d);
        ok = (d & m) != 8'h00;
      end
  endtask
endmodule

//--- test/io_port_decode_chk.sv
/*
  Assertions on the I/O port block pins.
  Assumes a bind onto io_port_decode; one clock domain.
*/
`timescale 1ns/1ps
module io_port_decode_chk
  import io_port_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire io_port_pkg::bus_req_s busReq,
  input wire logic [7:0] rdData,
  input wire logic rdDataOe,
  input wire logic [5:0] groupSelect,
  input wire logic alternateOrder,
  input wire logic softwareMode,
  input wire logic [3:0] chanRead,
  input wire logic [3:0] chanWrite,
  input wire logic [3:0] conditionOut,
  input wire logic configLoad,
  input wire logic [3:0] holdLatch
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire hit = busReq.addr[7:2] == groupSelect;
  wire [1:0] slot = busReq.addr[1:0] ^ {alternateOrder, 1'b0};
  sequence s_rdHit; busReq.rd && hit; endsequence
  sequence s_wrC; busReq.wr && hit && slot == 2'h2; endsequence
  property p_idle; !(busReq.rd && hit) |=> !rdDataOe && rdData == 8'h00;
  endproperty
  property p_answer; s_rdHit |=> rdDataOe; endproperty
  property p_miss; !hit |-> chanRead == 4'h0; endproperty
  property p_def;
    s_rdHit ##0 !alternateOrder |-> chanRead == 4'h1 << busReq.addr[1:0];
  endproperty
  property p_alt;
    s_rdHit ##0 alternateOrder |-> chanRead == 4'h1 << slot;
  endproperty
  property p_cond; s_wrC |=> conditionOut == $past(busReq.wrData[7:4]);
  endproperty
  property p_latch;
    s_wrC |=> holdLatch == $past(busReq.wrData[3:0]) && chanWrite == 4'h4;
  endproperty
  property p_load; s_wrC ##0 softwareMode |=> configLoad; endproperty
  a_idle: assert property (p_idle)
    else $error("data driven without a hit read");
  a_answer: assert property (p_answer)
    else $error("hit read not answered");
  a_miss: assert property (p_miss)
    else $error("channel selected on a miss");
  a_def: assert property (p_def)
    else $error("default channel order wrong");
  a_alt: assert property (p_alt)
    else $error("alternate channel order wrong");
  a_cond: assert property (p_cond)
    else $error("condition bits wrong");
  a_latch: assert property (p_latch)
    else $error("holding latch wrong");
  a_load: assert property (p_load)
    else $error("load strobe missing");
endmodule

//--- test/tb.sv
/*
  Self-checking bench of the I/O port block.
  Assumes host_model drives the bus; checker bound below.
*/
`timescale 1ns/1ps
module tb;
  import io_port_pkg::*;
  logic clock, rst_n, alt, sw, drv, cfgLoad, drvOut;
  logic [5:0] grp;
  logic [12:0] src;
  status_sel_t sel;
  bus_req_s busReq;
  logic [7:0] rdData, outD;
  logic flagA, flagB;
  logic [3:0] cond, latch, chanWrite;
  int err_count, check_count, cyc;
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  io_port_decode DUT (.clock(clock), .rst_n(rst_n), .busReq(busReq),
    .rdData(rdData), .rdDataOe(), .groupSelect(grp), .alternateOrder(alt),
    .softwareMode(sw), .driverFromBit1(drv), .statusSelect(sel),
    .parity_error(src[0]), .framing_error(src[1]), .overrun_error(src[2]),
    .receive_word_ready(src[3]), .transmit_buffer_empty(src[4]),
    .ext_avail_strobe_a(src[5]), .ext_avail_strobe_b(src[6]),
    .ext_received_latch_a(src[7]), .ext_received_latch_b(src[8]),
    .eiaIn(src[12:9]), .chanAIn(8'h5a), .chanBIn(8'ha5),
    .serialRxData(8'h3c), .chanRead(), .chanWrite(chanWrite),
    .outData(outD), .conditionOut(cond), .configLoad(cfgLoad),
    .holdLatch(latch), .driverOut(drvOut), .ext_avail_flag_a(flagA),
    .ext_avail_flag_b(flagB));
  host_model host (.clock(clock), .busReq(busReq), .rdData(rdData));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_order;
    logic [7:0] d;
    logic [7:0] val [4];
    logic [5:0] gl [3];
    val = '{8'h5a, 8'ha5, 8'h00, 8'h3c};
    gl = '{6'h00, 6'h15, 6'h3e};
    for (int g = 0; g < 3; g++)
      for (int a = 0; a < 2; a++)
      begin
        grp <= gl[g];
        alt <= a[0];
        for (int i = 0; i < 4; i++)
        begin
          host.rd({gl[g], i[1:0]}, d);
          chk("order", val[i[1:0] ^ {a[0], 1'b0}], d);
        end
        host.rd({~gl[g], 2'b10}, d);
        chk("miss", 8'h00, d);
      end
    $display("order done");
  endtask
  task t_write;
    alt <= 1'b0;
    host.tele({grp, 2'b10}, 4'h5);
    chk("split", 8'hf5, {cond, latch});
    chk("strobe", 8'h14, {3'h0, cfgLoad, chanWrite});
    chk("drv0", 8'h01, {7'h0, drvOut});
    chk("data", 8'hf5, outD);
    @(posedge clock);
    drv <= 1'b1;
    host.wr({~grp, 2'b10}, 8'h3a);
    chk("ignored", 8'hf5, {cond, latch});
    chk("drv1", 8'h00, {7'h0, drvOut});
    chk("dataMiss", 8'hf5, outD);
    @(posedge clock);
    sw <= 1'b0;
    host.wr({grp, 2'b10}, 8'h3a);
    chk("fixed", 8'h13, {cfgLoad, cond});
    @(posedge clock);
    sw <= 1'b1;
    @(negedge clock);
    chk("quiet", 8'h00, {7'h0, cfgLoad});
    @(posedge clock);
    $display("write done");
  endtask
  task t_status;
    logic [7:0] d;
    logic ok;
    for (int c = 0; c < 16; c++)
    begin
      sel <= {8{c[3:0]}};
      src <= (c > 0 && c < 14) ? 13'h1 << (c - 1) : '1;
      @(posedge clock);
      host.rd({grp, 2'b10}, d);
      chk("status", (c > 0 && c < 14) ? 8'hff : 8'h00, d);
      if (c == 0)
        chk("flags", 8'h03, {6'h0, flagB, flagA});
      if (c > 0 && c < 14)
      begin
        src <= ~(13'h1 << (c - 1));
        if (c == 6 || c == 7)
          host.rd({grp, c[1:0] ^ 2'h2}, d);
        host.rd({grp, 2'b10}, d);
        chk("status0", 8'h00, d);
      end
    end
    sel <= {8{SRC_RECEIVE_READY}};
    src <= 13'h008;
    host.poll({grp, 2'b10}, 8'h01, ok);
    chk("poll", 8'h01, {7'h0, ok});
    $display("status done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      wrap_up;
    end
  end
  initial
  begin
    rst_n = 1'b0;
    {grp, alt, sw, drv} = 9'h002;
    sel = '0;
    src = '0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_order;
    t_write;
    t_status;
    wrap_up;
  end
endmodule
bind io_port_decode io_port_decode_chk u_chk (.clock(clock), .rst_n(rst_n),
  .busReq(busReq), .rdData(rdData), .rdDataOe(rdDataOe),
  .groupSelect(groupSelect), .alternateOrder(alternateOrder),
  .softwareMode(softwareMode), .chanRead(chanRead), .chanWrite(chanWrite),
  .conditionOut(conditionOut), .configLoad(configLoad),
  .holdLatch(holdLatch));
